/* File: hdl/sprc_pkg.sv */
// Shared constants and types for the sampling and parallel readout block.
`default_nettype none

package sprc_pkg;

  localparam int unsigned CHANNELS   = 8;
  localparam int unsigned CH_W       = 3;
  localparam int unsigned CODE_W     = 14;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned PAD_W      = 2;
  localparam int unsigned GROUP_A_LAST = 3;
  localparam int unsigned FIFO_DEPTH = 2;

  // Clock period and longest conversion time; the count rounds down.
  localparam int unsigned CLOCK_PERIOD_PS    = 5000;
  localparam int unsigned CONVERSION_TIME_NS = 4000;
  localparam int unsigned CONV_CYCLES_INT    =
    (CONVERSION_TIME_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int unsigned CONV_CNT_W = 10;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST =
    CONV_CNT_W'(CONV_CYCLES_INT - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_ZERO = 10'h000;

  localparam logic [CH_W-1:0]  FIRST_CHANNEL  = 3'h0;
  localparam logic [CH_W-1:0]  CHANNEL_STEP   = 3'h1;
  localparam logic [PAD_W-1:0] PAD_ZERO       = 2'h0;
  localparam logic [3:0]       READS_PER_FRAME = 4'h8;
  localparam logic [3:0]       READS_ZERO     = 4'h0;
  localparam logic [3:0]       READS_STEP     = 4'h1;
  localparam logic [1:0]       FIFO_FULL      = 2'h2;
  localparam logic [1:0]       FIFO_EMPTY     = 2'h0;
  localparam logic [1:0]       FIFO_STEP      = 2'h1;
  localparam logic             START_IDLE     = 1'b0;
  localparam logic             STROBE_IDLE    = 1'b1;
  localparam logic [WORD_W-1:0] WORD_ZERO     = 16'h0000;

  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_BYTE,
    MODE_SERIAL
  } sprc_mode_t;

  typedef enum logic {
    ST_SAMPLE,
    ST_CONVERT
  } sprc_state_t;

  typedef struct packed {
    logic [CH_W-1:0]   channel;
    logic [WORD_W-1:0] word;
  } sprc_entry_t;

  typedef logic [CHANNELS-1:0][CODE_W-1:0] sprc_samples_t;
  typedef logic [CHANNELS-1:0][WORD_W-1:0] sprc_words_t;

endpackage

`default_nettype wire

/* File: hdl/sprc_readout.sv */
// Eight-channel sampling control, result latch and parallel readout.
`timescale 1ns/1ps
`default_nettype none

module sprc_readout
  import sprc_pkg::*;
(
  input  wire logic          i_clock,
  input  wire logic          i_resetn,
  input  wire logic          i_group_a_start,
  input  wire logic          i_group_b_start,
  input  wire sprc_samples_t i_analog_sample,
  input  wire logic          i_interface_select,
  input  wire logic          i_byte_or_serial_select,
  input  wire logic          i_chip_select_n,
  input  wire logic          i_read_n,
  output logic               o_busy,
  output logic [WORD_W-1:0]  o_parallel_data,
  output logic               o_parallel_data_oe,
  output logic               o_first_channel_flag,
  output logic               o_first_channel_flag_oe,
  output sprc_mode_t         o_interface_mode
);

  sprc_state_t           state;
  logic                  a_prev;
  logic                  b_prev;
  logic                  cs_prev;
  logic                  rd_prev;
  logic                  held_a;
  logic                  held_b;
  logic [CONV_CNT_W-1:0] conv_count;
  sprc_samples_t         held;
  sprc_words_t           results;
  sprc_entry_t           fifo [FIFO_DEPTH];
  sprc_entry_t           next_fifo [FIFO_DEPTH];
  logic [1:0]            fifo_count;
  logic [1:0]            next_count;
  logic [CH_W-1:0]       fill_ch;
  logic                  read_pending;
  logic [3:0]            read_count;
  sprc_mode_t            next_mode;

  logic        a_rise;
  logic        b_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        rd_fall;
  logic        hold_a_now;
  logic        hold_b_now;
  logic        both_held;
  logic        conv_done;
  logic        parallel;
  logic        frame_done;
  logic        flush;
  logic        push;
  logic        pop;
  sprc_entry_t fill_entry;

  assign a_rise  = i_group_a_start & ~a_prev;
  assign b_rise  = i_group_b_start & ~b_prev;
  assign cs_fall = ~i_chip_select_n & cs_prev;
  assign cs_rise = i_chip_select_n & ~cs_prev;
  // A read edge counts only while the chip is selected.
  assign rd_fall = ~i_read_n & rd_prev & ~i_chip_select_n;

  assign hold_a_now = (state == ST_SAMPLE) & a_rise & ~held_a;
  assign hold_b_now = (state == ST_SAMPLE) & b_rise & ~held_b;
  // A shared start raises both edges in one cycle.
  assign both_held  = (held_a | hold_a_now) & (held_b | hold_b_now);
  assign conv_done  = (state == ST_CONVERT) & (conv_count == CONV_LAST);

  assign parallel   = ~i_interface_select;
  assign frame_done = (read_count == READS_PER_FRAME);
  // Tied strobes raise chip select between words, so only a complete
  // frame rewinds the pointer on that edge.
  assign flush      = conv_done | (cs_rise & frame_done);
  assign push       = ~flush & (fifo_count != FIFO_FULL);
  assign pop        = ~flush & read_pending & (fifo_count != FIFO_EMPTY);
  assign fill_entry = '{channel: fill_ch, word: results[fill_ch]};

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      a_prev  <= START_IDLE;
      b_prev  <= START_IDLE;
      cs_prev <= STROBE_IDLE;
      rd_prev <= STROBE_IDLE;
    end else begin
      a_prev  <= i_group_a_start;
      b_prev  <= i_group_b_start;
      cs_prev <= i_chip_select_n;
      rd_prev <= i_read_n;
    end
  end

  // Sampling and conversion sequence; starts during conversion are ignored.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state      <= ST_SAMPLE;
      held_a     <= 1'b0;
      held_b     <= 1'b0;
      conv_count <= CONV_ZERO;
      o_busy     <= 1'b0;
    end else begin
      unique case (state)
        ST_SAMPLE: begin
          if (both_held) begin
            state      <= ST_CONVERT;
            held_a     <= 1'b0;
            held_b     <= 1'b0;
            conv_count <= CONV_ZERO;
            o_busy     <= 1'b1;
          end else begin
            held_a <= held_a | hold_a_now;
            held_b <= held_b | hold_b_now;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state  <= ST_SAMPLE;
            o_busy <= 1'b0;
          end else begin
            conv_count <= conv_count + CONV_CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Per-channel hold and result registers; all channels are converted.
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
    logic hold_now;
    assign hold_now = (ch <= GROUP_A_LAST) ? hold_a_now : hold_b_now;
    always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
        held[ch]    <= '0;
        results[ch] <= WORD_ZERO;
      end else begin
        if (hold_now) begin
          held[ch] <= i_analog_sample[ch];
        end
        if (conv_done) begin
          results[ch] <= {held[ch], PAD_ZERO};
        end
      end
    end
  end

  // Two-entry buffer between the result registers and the bus.
  always_comb begin
    next_count = fifo_count;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      next_fifo[i] = fifo[i];
    end
    if (pop) begin
      next_fifo[0] = fifo[1];
      next_count   = fifo_count - FIFO_STEP;
    end
    if (push) begin
      next_fifo[next_count[0]] = fill_entry;
      next_count = next_count + FIFO_STEP;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fifo_count <= FIFO_EMPTY;
      fill_ch    <= FIRST_CHANNEL;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo[i] <= '0;
      end
    end else if (flush) begin
      fifo_count <= FIFO_EMPTY;
      fill_ch    <= FIRST_CHANNEL;
    end else begin
      fifo_count <= next_count;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo[i] <= next_fifo[i];
      end
      if (push) begin
        fill_ch <= fill_ch + CHANNEL_STEP;
      end
    end
  end

  // A read edge waits here until a word is ready; set beats clear.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      read_pending <= 1'b0;
    end else if (rd_fall & parallel) begin
      read_pending <= 1'b1;
    end else if (pop) begin
      read_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      read_count <= READS_ZERO;
    end else if (flush) begin
      read_count <= READS_ZERO;
    end else if (pop && !frame_done) begin
      read_count <= read_count + READS_STEP;
    end
  end

  // Bus drive and data; the bus stays off outside parallel mode.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_parallel_data    <= WORD_ZERO;
      o_parallel_data_oe <= 1'b0;
    end else begin
      if (cs_rise || !parallel) begin
        o_parallel_data_oe <= 1'b0;
      end else if (cs_fall || rd_fall) begin
        o_parallel_data_oe <= 1'b1;
      end
      if (pop) begin
        o_parallel_data <= fifo[0].word;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_first_channel_flag    <= 1'b0;
      o_first_channel_flag_oe <= 1'b0;
    end else begin
      if (cs_rise || !parallel) begin
        o_first_channel_flag_oe <= 1'b0;
        o_first_channel_flag    <= 1'b0;
      end else if (pop) begin
        o_first_channel_flag_oe <= 1'b1;
        o_first_channel_flag <= (fifo[0].channel == FIRST_CHANNEL);
      end
    end
  end

  always_comb begin
    if (!i_interface_select) begin
      next_mode = MODE_PARALLEL;
    end else if (i_byte_or_serial_select) begin
      next_mode = MODE_BYTE;
    end else begin
      next_mode = MODE_SERIAL;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_interface_mode <= MODE_PARALLEL;
    end else begin
      o_interface_mode <= next_mode;
    end
  end

  localparam int CONV_HI = 1000;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  sequence s_both_held;
    (state == ST_SAMPLE) && both_held;
  endsequence

  sequence s_first_pop;
    pop && (read_count == READS_ZERO);
  endsequence

  a_busy_starts: assert property (s_both_held |=> $rose(o_busy))
    else $error("busy did not rise after both groups were held");

  a_busy_bounded: assert property ($rose(o_busy) |-> ##[1:CONV_HI] !o_busy)
    else $error("busy stayed high past the conversion time");

  a_group_wait: assert property ((state == ST_SAMPLE) && held_a && !held_b
    && !b_rise |=> !o_busy)
    else $error("conversion began before group B was sampled");

  a_result_latch: assert property (conv_done |=> !o_busy
    && results[0] == {$past(held[0]), PAD_ZERO})
    else $error("results not latched as busy fell");

  a_busy_stable: assert property (o_busy |-> $stable(results))
    else $error("results changed while busy was high");

  a_first_word: assert property (s_first_pop |=> o_first_channel_flag
    && o_parallel_data == results[0])
    else $error("first read did not give channel one with flag");

  a_flag_drop: assert property (pop && fifo[0].channel != FIRST_CHANNEL
    |=> !o_first_channel_flag)
    else $error("first channel flag high on a later channel");

  a_frame_end: assert property (cs_rise |=> !o_parallel_data_oe
    && !o_first_channel_flag_oe)
    else $error("bus or flag still driven after frame end");

  a_low_bits: assert property (o_parallel_data_oe
    |-> o_parallel_data[PAD_W-1:0] == PAD_ZERO)
    else $error("low bus lines not driven low");

  a_pointer_rewind: assert property (flush |=> fifo_count == FIFO_EMPTY
    && fill_ch == FIRST_CHANNEL ##1 fifo[0].channel == FIRST_CHANNEL)
    else $error("readout pointer not rewound to channel one");

  a_mode_select: assert property (##1 (o_interface_mode == MODE_SERIAL)
    == $past(i_interface_select && !i_byte_or_serial_select))
    else $error("serial mode decode wrong");

endmodule

`default_nettype wire

/* File: sim/sprc_host.sv */
// Host controller model that drives the conversion starts and read strobes.
`timescale 1ns/1ps
`default_nettype none

module sprc_host
  import sprc_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic [WORD_W-1:0] i_data,
  input  wire logic              i_flag,
  input  wire logic              i_data_oe,
  output logic                   o_group_a_start,
  output logic                   o_group_b_start,
  output logic                   o_chip_select_n,
  output logic                   o_read_n
);
  initial begin
    o_group_a_start = START_IDLE;
    o_group_b_start = START_IDLE;
    o_chip_select_n = STROBE_IDLE;
    o_read_n        = STROBE_IDLE;
  end

  // Raising both starts in one step gives a single shared sampling instant.
  task automatic set_starts(input logic a, input logic b);
    @(negedge i_clock);
    o_group_a_start = a;
    o_group_b_start = b;
  endtask

  task automatic chip_select(input logic level_n);
    @(negedge i_clock);
    o_chip_select_n = level_n;
  endtask

  // With tied strobes chip select follows read; otherwise it is left alone.
  task automatic read_word(input logic tied, output logic [WORD_W-1:0] w,
                           output logic f, output logic oe);
    @(negedge i_clock);
    o_read_n = 1'b0;
    if (tied) o_chip_select_n = 1'b0;
    repeat (2) @(negedge i_clock);
    // A bus that is not driven reads back as the inverse of its last value.
    w  = i_data_oe ? i_data : ~i_data;
    f  = i_flag;
    oe = i_data_oe;
    o_read_n = 1'b1;
    if (tied) o_chip_select_n = 1'b1;
  endtask
endmodule

`default_nettype wire

/* File: sim/tb_sprc_readout.sv */
// Self-checking testbench for the sampling and parallel readout block.
`timescale 1ns/1ps
`default_nettype none

module tb_sprc_readout;
  import sprc_pkg::*;

  logic              clock  = 1'b0;
  logic              resetn = 1'b0;
  logic              a_start, b_start, cs_n, rd_n;
  logic              if_sel = 1'b0;
  logic              bs_sel = 1'b0;
  sprc_samples_t     analog = '0;
  sprc_samples_t     held   = '0;
  logic              busy, data_oe, flag, flag_oe;
  logic [WORD_W-1:0] data;
  sprc_mode_t        mode;
  int                fail_count      = 0;
  int                samples_checked = 0;

  always #2.5 clock = ~clock;

  sprc_readout i_sprc_readout (
    .i_clock(clock), .i_resetn(resetn),
    .i_group_a_start(a_start), .i_group_b_start(b_start),
    .i_analog_sample(analog), .i_interface_select(if_sel),
    .i_byte_or_serial_select(bs_sel), .i_chip_select_n(cs_n),
    .i_read_n(rd_n), .o_busy(busy), .o_parallel_data(data),
    .o_parallel_data_oe(data_oe), .o_first_channel_flag(flag),
    .o_first_channel_flag_oe(flag_oe), .o_interface_mode(mode)
  );

  sprc_host i_sprc_host (
    .i_clock(clock), .i_data(data), .i_flag(flag), .i_data_oe(data_oe),
    .o_group_a_start(a_start), .o_group_b_start(b_start),
    .o_chip_select_n(cs_n), .o_read_n(rd_n)
  );

  function automatic sprc_samples_t pattern(input logic [7:0] base);
    sprc_samples_t s;
    for (int c = 0; c < CHANNELS; c++) s[c] = {base, 3'h0, 3'(c)};
    return s;
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Reads all eight words of one frame, then ends the frame.
  task automatic read_frame(input logic tied);
    logic [WORD_W-1:0] w;
    logic              f, oe;
    if (!tied) i_sprc_host.chip_select(1'b0);
    for (int c = 0; c < CHANNELS; c++) begin
      i_sprc_host.read_word(tied, w, f, oe);
      check("data", w, {held[c], PAD_ZERO});
      check("flag", f, c == 0);
      check("oe", oe, 1'b1);
      check("flag oe", flag_oe, 1'b1);
    end
    if (!tied) i_sprc_host.chip_select(1'b1);
    repeat (2) @(negedge clock);
    check("oe idle", {data_oe, flag_oe}, 2'h0);
  endtask

  // Runs one conversion; group B sees s_b only when the starts are split.
  task automatic run_conv(input logic split, input sprc_samples_t s_a,
                          input sprc_samples_t s_b, input logic rb);
    logic [WORD_W-1:0] w;
    logic              f, oe;
    int                n;
    n = 0;
    analog = s_a;
    i_sprc_host.set_starts(1'b1, !split);
    if (split) begin
      repeat (5) @(negedge clock);
      check("busy held off", busy, 1'b0);
      analog = s_b;
      i_sprc_host.set_starts(1'b1, 1'b1);
    end
    check("busy early", busy, 1'b0);
    @(negedge clock);
    check("busy rise", busy, 1'b1);
    analog = ~analog;
    if (rb) begin
      i_sprc_host.read_word(1'b1, w, f, oe);
      check("busy read", w, {held[0], PAD_ZERO});
      check("busy during read", busy, 1'b1);
    end
    while (busy === 1'b1 && n < 1000) begin
      n++;
      @(negedge clock);
    end
    if (!rb) check("busy cycles", n, CONV_CYCLES_INT);
    i_sprc_host.set_starts(1'b0, 1'b0);
    for (int c = 0; c < CHANNELS; c++)
      held[c] = (c <= GROUP_A_LAST) ? s_a[c] : s_b[c];
  endtask

  task automatic test_modes();
    logic [WORD_W-1:0] w;
    logic              f, oe;
    logic [1:0]        sel [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    sprc_mode_t        want [4] = '{MODE_PARALLEL, MODE_PARALLEL,
                                    MODE_BYTE, MODE_SERIAL};
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      {if_sel, bs_sel} = sel[i];
      repeat (2) @(negedge clock);
      check("mode", mode, want[i]);
      i_sprc_host.read_word(1'b1, w, f, oe);
      check("mode oe", oe, i < 2);
      if (i == 0) check("reset word", w, WORD_ZERO);
    end
    @(negedge clock);
    {if_sel, bs_sel} = 2'h0;
    $display("test modes done");
  endtask

  task automatic test_shared();
    run_conv(1'b0, pattern(8'h11), pattern(8'h11), 1'b0);
    read_frame(1'b1);
    $display("test shared start done");
  endtask

  task automatic test_busy_read();
    run_conv(1'b0, pattern(8'h22), pattern(8'h22), 1'b1);
    read_frame(1'b1);
    $display("test read during busy done");
  endtask

  task automatic test_split();
    run_conv(1'b1, pattern(8'h33), pattern(8'h44), 1'b0);
    read_frame(1'b0);
    $display("test split start done");
  endtask

  // A reset in mid-run clears the outputs and the result words.
  task automatic test_reset();
    logic [WORD_W-1:0] w;
    logic              f, oe;
    @(negedge clock);
    resetn = 1'b0;
    @(negedge clock);
    check("reset outputs", {busy, data_oe, flag, flag_oe}, 4'h0);
    check("reset data", data, WORD_ZERO);
    resetn = 1'b1;
    i_sprc_host.read_word(1'b1, w, f, oe);
    check("reset read", w, WORD_ZERO);
    check("reset flag", f, 1'b1);
    $display("test reset done");
  endtask

  initial begin
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    test_modes();
    test_shared();
    test_busy_read();
    test_split();
    test_reset();
    conclude();
  end

  // Three conversions and their frames take well under this span.
  initial begin
    repeat (10000) @(posedge clock);
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    conclude();
  end
endmodule

`default_nettype wire
